// ==== rrss_pkg.sv ====
package rrss_pkg;
  localparam int         REG_CTRL     = 0;
  localparam int         REG_STRAPS   = 1;
  localparam int         REG_STATUS   = 2;
  localparam int         REG_IRQ_STAT = 3;
  localparam int         REG_IRQ_MASK = 4;
  localparam int         REG_ID       = 5;
  localparam logic [4:0] ADDR_MSB     = 5'h04;
  localparam int         ADDR_LSB     = 2;

  localparam int         CTRL_RUN       = 0;
  localparam int         CTRL_PT_SEL_LO = 1;

  localparam int         IRQ_SETTLED = 0;
  localparam int         IRQ_BLOCK   = 1;
  localparam int         IRQ_ERROR   = 2;
  localparam int         IRQ_W       = 3;

  localparam logic [3:0] PART_ID_DEF  = 4'h5; // Arbitrary value
  localparam logic [3:0] REVISION_DEF = 4'h1; // Arbitrary value

  localparam int         BLOCK_FRAMES = 192;
  localparam int         BLK_DELAY    = 2;
  localparam int         BLK_HIGH     = 16;
  localparam int         FRAME_CW     = 8;

  localparam int         MCLK_256X = 256;
  localparam int         MCLK_128X = 128;

  typedef struct packed {
    logic phase_detector_type;
    logic error_is_receiver;
    logic serial_format_select_hi;
    logic emphasis_match;
    logic port_is_master;
    logic serial_format_select_lo;
    logic mclk_is_128x;
    logic i2c_addr_bit;
    logic software_config;
  } rrss_straps_t;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_LOWPWR  = 2'b01,
    ST_SETTLE  = 2'b10,
    ST_RUNNING = 2'b11
  } rrss_state_t;
endpackage

// ==== rrss_top.sv ====
// Notes on behaviour
// - While reset is low the block is in low power, all state but the strap sampling pipe clears and all outputs are muted.
// - In software configuration the registers load after reset and processing starts on RUN=1.
// - Serial audio outputs stay disabled until the clock recovery loop reports it has settled.
// - Strap pins are inputs during reset, sampled at its exit, then driven as outputs.
// - In software configuration only the output-two and audio-data straps take effect.
// - Passthrough drives the selected receiver input through one register; its strap picks phase detector.
// - Error pin strap low selects non-validity errors, high selects general receiver errors.
// - Audio status pin is low for valid linear PCM; its strap sets the upper format bit.
// - High-rate pin is 1 at or above 88.1 kHz, 0 at or below 48 kHz; strap sets emphasis match.
// - Block start rises two frames after a Z preamble, holds 16 frames, then stays low.
// - Block start strap chooses serial port clock master or slave.
// - Channel status bit shifts out on the rising word-clock edge only; strap sets lower format bit.
// - User bit shifts out on the rising word-clock edge only; strap chooses 256x or 128x master clock.
// - A readable 4-bit part code and a separate 4-bit revision code are provided.
// - Master clock ratio is 256x with the user strap low and 128x with it high.
// - Audio-data strap low selects hardware configuration, high selects software.
//
// Local design decisions: the Wishbone slave port and the register offsets.
module rrss_top #(
  parameter logic [3:0] PART_ID  = rrss_pkg::PART_ID_DEF,
  parameter logic [3:0] REVISION = rrss_pkg::REVISION_DEF
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire logic [3:0]  rx_inputs,
  input  wire logic [1:0]  passthrough_input_select,
  output logic             passthrough_out,
  input  wire logic        passthrough_in,
  input  wire logic        pll_settled,
  input  wire logic        frame_tick,
  input  wire logic        z_preamble,
  input  wire logic        word_clock_edge,
  input  wire logic        cs_bit_rx,
  input  wire logic        user_bit_rx,
  input  wire logic        nonvalidity_error_flag,
  input  wire logic        receiver_error_flag,
  input  wire logic        stream_non_pcm,
  input  wire logic        rate_high,
  input  wire logic [8:0]  strap_in,
  output logic      [8:0]  strap_oe,
  output logic             error_indicator_pin,
  output logic             audio_status_pin,
  output logic             high_rate_detect,
  output logic             block_start_indicator,
  output logic             channel_status_out,
  output logic             user_bit_out,
  output logic             general_output_two,
  output logic             serial_audio_enable,
  output logic             low_power,
  output logic             mclk_is_128x,
  output logic [8:0]       mclk_ratio
);
  logic                  rst_m;
  logic                  rst_n;
  logic [8:0]            strap_m;
  logic [8:0]            strap_s;
  logic [5:0]            in_m;
  logic [5:0]            in_s;
  logic                  strap_taken;
  rrss_pkg::rrss_straps_t straps;
  rrss_pkg::rrss_state_t  state;
  logic                  run_bit;
  logic [rrss_pkg::IRQ_W-1:0] irq_stat;
  logic [rrss_pkg::IRQ_W-1:0] irq_mask;
  logic [rrss_pkg::IRQ_W-1:0] irq_evt;
  logic [rrss_pkg::FRAME_CW-1:0] frame_cnt;
  logic                  blk_active;
  logic                  wb_hit;
  logic [2:0]            reg_idx;
  logic [31:0]           rd_data;
  logic                  active;
  logic                  wb_wr;
  logic                  wce_d;
  logic                  tick_d;
  logic                  wce_rise;
  logic                  tick_rise;
  logic                  blk_evt;
  rrss_pkg::rrss_straps_t raw_straps;
  rrss_pkg::rrss_straps_t next_straps;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // No reset here, so the pipe already holds the pulled levels at release
  always_ff @(posedge clk) begin
    strap_m <= strap_in;
    strap_s <= strap_m;
  end

  // Pins from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_m    <= 6'h00;
      in_s    <= 6'h00;
    end else begin
      in_m    <= {pll_settled, z_preamble, frame_tick, word_clock_edge, rate_high, stream_non_pcm};
      in_s    <= in_m;
    end
  end

  // Strobes act once per pulse; cleared to the idle level of their pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wce_d  <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      wce_d  <= in_s[2];
      tick_d <= in_s[3];
    end
  end

  assign wce_rise  = in_s[2] && !wce_d;
  assign tick_rise = in_s[3] && !tick_d;
  assign blk_evt   = tick_rise && in_s[4];

  // Software config keeps only the address and mode straps
  always_comb begin
    raw_straps  = rrss_pkg::rrss_straps_t'(strap_s);
    next_straps = raw_straps;
    if (raw_straps.software_config) begin
      next_straps                 = '0;
      next_straps.i2c_addr_bit    = raw_straps.i2c_addr_bit;
      next_straps.software_config = 1'b1;
    end
  end

  // Straps are caught on the first edge after release; pins stay inputs until then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      straps      <= '0;
      strap_oe    <= 9'h000;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      straps      <= next_straps;
      strap_oe    <= 9'h1ff;
    end
  end

  // Outputs carry live data only once processing has started
  assign active = strap_taken && (state == rrss_pkg::ST_SETTLE || state == rrss_pkg::ST_RUNNING);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rrss_pkg::ST_RESET;
    end else begin
      unique case (state)
        rrss_pkg::ST_RESET: begin
          if (strap_taken) begin
            state <= rrss_pkg::ST_LOWPWR;
          end
        end
        rrss_pkg::ST_LOWPWR: begin
          if (!straps.software_config || run_bit) begin
            state <= rrss_pkg::ST_SETTLE;
          end
        end
        rrss_pkg::ST_SETTLE: begin
          if (in_s[5]) begin
            state <= rrss_pkg::ST_RUNNING;
          end
        end
        rrss_pkg::ST_RUNNING: begin
          if (straps.software_config && !run_bit) begin
            state <= rrss_pkg::ST_LOWPWR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power           <= 1'b1;
      serial_audio_enable <= 1'b0;
      mclk_is_128x        <= 1'b0;
      mclk_ratio          <= 9'(rrss_pkg::MCLK_256X);
      general_output_two  <= 1'b0;
    end else begin
      low_power           <= (state == rrss_pkg::ST_RESET || state == rrss_pkg::ST_LOWPWR);
      serial_audio_enable <= (state == rrss_pkg::ST_RUNNING);
      mclk_is_128x        <= !straps.software_config && straps.mclk_is_128x;
      mclk_ratio          <= (!straps.software_config && straps.mclk_is_128x) ?
                             9'(rrss_pkg::MCLK_128X) : 9'(rrss_pkg::MCLK_256X);
      general_output_two  <= active && straps.software_config && straps.i2c_addr_bit;
    end
  end

  // Frame count since the last Z preamble drives the block marker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt  <= '0;
      blk_active <= 1'b0;
    end else if (blk_evt) begin
      frame_cnt  <= '0;
      blk_active <= 1'b1;
    end else if (tick_rise && blk_active) begin
      if (frame_cnt == rrss_pkg::FRAME_CW'(rrss_pkg::BLOCK_FRAMES - 1)) begin
        blk_active <= 1'b0;
      end
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_start_indicator <= 1'b0;
    end else begin
      block_start_indicator <= active && blk_active &&
        frame_cnt >= rrss_pkg::FRAME_CW'(rrss_pkg::BLK_DELAY) &&
        frame_cnt < rrss_pkg::FRAME_CW'(rrss_pkg::BLK_DELAY + rrss_pkg::BLK_HIGH);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_status_out  <= 1'b0;
      user_bit_out        <= 1'b0;
      error_indicator_pin <= 1'b0;
      audio_status_pin    <= 1'b0;
      high_rate_detect    <= 1'b0;
      passthrough_out     <= 1'b0;
    end else begin
      if (!active) begin
        channel_status_out <= 1'b0;
        user_bit_out       <= 1'b0;
      end else if (wce_rise) begin
        channel_status_out <= cs_bit_rx;
        user_bit_out       <= user_bit_rx;
      end
      error_indicator_pin <= active && (straps.error_is_receiver ?
                             receiver_error_flag : nonvalidity_error_flag);
      audio_status_pin    <= active && in_s[0];
      high_rate_detect    <= active && in_s[1];
      passthrough_out     <= active && rx_inputs[passthrough_input_select];
    end
  end

  // Wishbone slave, one wait state; unmapped words read zero
  assign reg_idx = wb_adr_i[rrss_pkg::ADDR_MSB:rrss_pkg::ADDR_LSB];
  assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge at which the master samples ack
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (reg_idx)
      3'(rrss_pkg::REG_CTRL):     rd_data = {31'h0000_0000, run_bit};
      3'(rrss_pkg::REG_STRAPS):   rd_data = {23'h00_0000, straps};
      3'(rrss_pkg::REG_STATUS):   rd_data = {28'h000_0000, serial_audio_enable, low_power, state};
      3'(rrss_pkg::REG_IRQ_STAT): rd_data = {29'h0000_0000, irq_stat};
      3'(rrss_pkg::REG_IRQ_MASK): rd_data = {29'h0000_0000, irq_mask};
      3'(rrss_pkg::REG_ID):       rd_data = {24'h00_0000, PART_ID, REVISION};
      default:                    rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run_bit  <= 1'b0;
      irq_mask <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
      if (wb_wr && straps.software_config) begin
        if (reg_idx == 3'(rrss_pkg::REG_CTRL)) begin
          run_bit <= wb_dat_i[rrss_pkg::CTRL_RUN];
        end
        if (reg_idx == 3'(rrss_pkg::REG_IRQ_MASK)) begin
          irq_mask <= wb_dat_i[rrss_pkg::IRQ_W-1:0];
        end
      end
    end
  end

  assign irq_evt = {active && (receiver_error_flag || nonvalidity_error_flag),
                    blk_evt && active,
                    state == rrss_pkg::ST_SETTLE && in_s[5]};

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      if (wb_wr && reg_idx == 3'(rrss_pkg::REG_IRQ_STAT)) begin
        irq_stat <= (irq_stat & ~wb_dat_i[rrss_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  logic unused_ok;
  assign unused_ok = ^{passthrough_in, wb_sel_i[3:1], wb_dat_i[31:8]};

  property p_mute_in_reset;
    @(posedge clk) !rst_n |-> (!serial_audio_enable && !block_start_indicator);
  endproperty
  a_mute_in_reset: assert property (p_mute_in_reset) else $error("outputs not muted");

  property p_run_needed;
    @(posedge clk) disable iff (!rst_n)
      (straps.software_config && !run_bit && state == rrss_pkg::ST_LOWPWR) |=>
      state == rrss_pkg::ST_LOWPWR;
  endproperty
  a_run_needed: assert property (p_run_needed) else $error("left low power w/o run");

  property p_enable_after_settle;
    @(posedge clk) disable iff (!rst_n)
      $rose(serial_audio_enable) |-> $past(state) == rrss_pkg::ST_RUNNING;
  endproperty
  a_enable_after_settle: assert property (p_enable_after_settle) else $error("early enable");

  property p_straps_hold;
    @(posedge clk) disable iff (!rst_n) strap_taken |=> $stable(straps);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("strap changed");

  property p_strap_oe;
    @(posedge clk) disable iff (!rst_n) strap_taken |-> strap_oe == 9'h1ff;
  endproperty
  a_strap_oe: assert property (p_strap_oe) else $error("strap pins not driven");

  property p_ratio;
    @(posedge clk) disable iff (!rst_n)
      strap_taken ##1 1'b1 |=> mclk_ratio ==
        ((!straps.software_config && straps.mclk_is_128x) ? 9'h080 : 9'h100);
  endproperty
  a_ratio: assert property (p_ratio) else $error("clock ratio wrong");

  property p_blk_width;
    @(posedge clk) disable iff (!rst_n)
      block_start_indicator |-> frame_cnt < rrss_pkg::FRAME_CW'(rrss_pkg::BLK_DELAY + rrss_pkg::BLK_HIGH) + 1'b1;
  endproperty
  a_blk_width: assert property (p_blk_width) else $error("block start too long");

  property p_hw_no_i2c;
    @(posedge clk) disable iff (!rst_n) !straps.software_config |-> !general_output_two;
  endproperty
  a_hw_no_i2c: assert property (p_hw_no_i2c) else $error("address strap misuse");

  c_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(serial_audio_enable));
  c_blk: cover property (@(posedge clk) disable iff (!rst_n) $rose(block_start_indicator));
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

// ==== rrss_board_model.sv ====
module rrss_board_model (
  input  wire logic       clk,
  input  wire logic [8:0] pulls,
  input  wire logic [8:0] strap_oe,
  input  wire logic [8:0] pin_out,
  output logic      [8:0] strap_in,
  output logic            frame_tick,
  output logic            z_preamble,
  output logic            word_clock_edge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase = 4'h0;
  logic [7:0] frame = 8'h00;
  // Frame of 16 clk keeps every pulse 4 clk wide, above the 3 clk minimum
  always_ff @(posedge clk) begin
    phase <= phase + 4'h1;
    if (phase == 4'hf)
      frame <= (frame == 8'(rrss_pkg::BLOCK_FRAMES - 1)) ? 8'h00 : frame + 8'h01;
  end
  // Released pin shows only its resistor; every pull, passthrough included, comes from pulls
  assign strap_in = (strap_oe & pin_out) | (~strap_oe & pulls);
  assign frame_tick = phase < 4'h4;
  assign word_clock_edge = phase[2:0] < 3'h4;
  assign z_preamble = frame_tick && frame == 8'h00;
endmodule

// ==== test_receiver_reset_strap_status.sv ====
module test_receiver_reset_strap_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, wb_ack_o, irq, frame_tick, z_preamble, word_clock_edge;
  logic        passthrough_out, error_indicator_pin, audio_status_pin, high_rate_detect;
  logic        block_start_indicator, channel_status_out, user_bit_out, general_output_two;
  logic        serial_audio_enable, low_power, mclk_is_128x;
  logic        arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        passthrough_in = 1'b0, pll_settled = 1'b0, cs_bit_rx = 1'b0;
  logic        user_bit_rx = 1'b0, nonvalidity_error_flag = 1'b0;
  logic        receiver_error_flag = 1'b0, stream_non_pcm = 1'b0, rate_high = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  rx_inputs = 4'h0;
  logic [1:0]  passthrough_input_select = 2'h2;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [8:0]  strap_in, strap_oe, mclk_ratio, pins, pulls = 9'h1ff;
  int          miscompares = 0, checked = 0, n;
  assign pins = {passthrough_out, error_indicator_pin, audio_status_pin, high_rate_detect,
                 block_start_indicator, channel_status_out, user_bit_out, general_output_two,
                 1'b0};
  rrss_top i_dut (
    .clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq, .rx_inputs, .passthrough_input_select,
    .passthrough_out, .passthrough_in, .pll_settled, .frame_tick, .z_preamble,
    .word_clock_edge, .cs_bit_rx, .user_bit_rx, .nonvalidity_error_flag,
    .receiver_error_flag, .stream_non_pcm, .rate_high, .strap_in, .strap_oe,
    .error_indicator_pin, .audio_status_pin, .high_rate_detect, .block_start_indicator,
    .channel_status_out, .user_bit_out, .general_output_two, .serial_audio_enable,
    .low_power, .mclk_is_128x, .mclk_ratio);
  rrss_board_model i_board (
    .clk, .pulls, .strap_oe, .pin_out(pins), .strap_in, .frame_tick, .z_preamble,
    .word_clock_edge);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  function automatic logic probe(input int i);
    case (i)
      0: return low_power;
      1: return serial_audio_enable;
      2: return z_preamble;
      3: return block_start_indicator;
      4: return word_clock_edge;
      default: return irq;
    endcase
  endfunction
  // Leaves the edge count in n for latency checks
  task automatic await(input int i, input logic v, input int lim);
    n = 0;
    while (probe(i) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) hang();
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) hang();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rst(input logic [8:0] p);
    arst_n <= 1'b0;
    pulls <= p;
    pll_settled <= 1'b0;
    cyc(6);
    chk(32'(low_power), 32'h1);
    chk(32'(pins), 32'h0);
    chk(32'(strap_oe), 32'h0);
    arst_n <= 1'b1;
    cyc(6);
    chk(32'(strap_oe), 32'h1ff);
  endtask
  task automatic sw_start;
    rst(9'h1ff);
    wb(1'b1, 5'h10, 32'h1);
    wb(1'b0, 5'h10, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, 5'h04, 32'h0);
    chk(q, 32'h003);
    chk(32'(mclk_ratio), 32'h100);
    wb(1'b0, 5'h14, 32'h0);
    chk(q & 32'hff, {24'h0, rrss_pkg::PART_ID_DEF, rrss_pkg::REVISION_DEF});
    wb(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0);
    cyc(20);
    chk(32'(low_power), 32'h1);
    wb(1'b1, 5'h00, 32'h1);
    await(0, 1'b0, 50);
    cyc(20);
    chk(32'(serial_audio_enable), 32'h0);
    pll_settled <= 1'b1;
    await(1, 1'b1, 50);
    await(5, 1'b1, 10);
    chk(32'(general_output_two), 32'h1);
    wb(1'b1, 5'h10, 32'h0);
    cyc(3);
    chk(32'(irq), 32'h0);
    wb(1'b1, 5'h0c, 32'h1);
    wb(1'b1, 5'h10, 32'h1);
    cyc(3);
    chk(32'(irq), 32'h0);
  endtask
  task automatic side_bits;
    cs_bit_rx <= 1'b0;
    user_bit_rx <= 1'b1;
    cyc(20);
    chk(32'({channel_status_out, user_bit_out}), 32'h1);
    await(4, 1'b1, 20);
    await(4, 1'b0, 20);
    cs_bit_rx <= 1'b1;
    user_bit_rx <= 1'b0;
    // No word-clock edge yet, so the outputs must not follow
    cyc(2);
    chk(32'({channel_status_out, user_bit_out}), 32'h1);
    cyc(10);
    chk(32'({channel_status_out, user_bit_out}), 32'h2);
  endtask
  task automatic block_start;
    await(2, 1'b0, 40);
    await(2, 1'b1, 4000);
    await(3, 1'b1, 60);
    chk(32'(n >= 32 && n <= 38), 32'h1);
    await(3, 1'b0, 400);
    chk(n, 32'h100);
    wb(1'b0, 5'h0c, 32'h0);
    chk(q & 32'h2, 32'h2);
  endtask
  task automatic hw_mode(input logic [8:0] p);
    rst(p);
    chk(32'(mclk_ratio), p[2] ? 32'h80 : 32'h100);
    chk(32'(mclk_is_128x), 32'(p[2]));
    cyc(2);
    chk(32'(low_power), 32'h0);
    wb(1'b1, 5'h00, 32'h1);
    wb(1'b0, 5'h00, 32'h0);
    chk(q, 32'h0);
    pll_settled <= 1'b1;
    rx_inputs <= 4'h4;
    stream_non_pcm <= 1'b1;
    rate_high <= 1'b1;
    receiver_error_flag <= 1'b1;
    nonvalidity_error_flag <= 1'b0;
    cyc(8);
    chk(32'(pins[8:5]), {28'h0, 1'b1, p[7], 2'b11});
    chk(32'(general_output_two), 32'h0);
    rx_inputs <= 4'hb;
    stream_non_pcm <= 1'b0;
    rate_high <= 1'b0;
    receiver_error_flag <= 1'b0;
    nonvalidity_error_flag <= 1'b1;
    cyc(8);
    chk(32'(pins[8:5]), {28'h0, 1'b0, ~p[7], 2'b00});
    // Pins have toggled since capture; the latch must not notice
    wb(1'b0, 5'h04, 32'h0);
    chk(q, 32'(p));
  endtask
  initial begin
    sw_start();
    side_bits();
    block_start();
    hw_mode(9'h1a6);
    hw_mode(9'h058);
    conclude();
  end
  initial begin
    cyc(40000);
    hang();
  end
endmodule
